/* tmc_pkg.sv */
package tmc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [11:0] TMC_MODE_OFS = 12'h000;
  localparam logic [11:0] TMC_LODMIN_OFS = 12'h004;
  localparam logic [11:0] TMC_SIZE_OFS = 12'h008;
  localparam logic [11:0] TMC_COUNT_OFS = 12'h00C;
  // Reset values.
  localparam logic [31:0] TMC_MODE_RESET = 32'h0000_0000;
  localparam logic [5:0] TMC_LODMIN_RESET = 6'h00;
  localparam logic [7:0] TMC_SIZE_RESET = 8'h88;
  // W of 1.0 in signed 4.12 form, and the fraction bits of S and T.
  localparam logic signed [15:0] TMC_W_ONE = 16'sh1000;
  localparam int unsigned TMC_W_FRAC = 12;
  localparam int unsigned TMC_ST_FRAC = 4;
  // Texture formats of 16 bits start at this code.
  localparam logic [3:0] TMC_FMT_WIDE = 4'h8;

  typedef enum logic [2:0] {
    TMC_F_ZERO,
    TMC_F_LOCAL,
    TMC_F_OTHER_A,
    TMC_F_LOCAL_A,
    TMC_F_LOD,
    TMC_F_LOD_FRAC
  } tmc_factor_type;

  // Control field of one combine unit, nine bits.
  typedef struct packed {
    logic invert_result;
    logic add_local_alpha;
    logic add_local_color;
    logic reverse_blend;
    logic [2:0] factor_select;
    logic sub_local;
    logic zero_other;
  } tmc_comb_type;

  // Layout of the texture mapping mode register, bit 31 first.
  typedef struct packed {
    logic seq_download;
    logic trilinear;
    tmc_comb_type alpha_unit;
    tmc_comb_type color_unit;
    logic [3:0] format;
    logic clamp_t;
    logic clamp_s;
    logic ncc_select;
    logic lod_dither;
    logic clamp_neg_w;
    logic mag_bilinear;
    logic min_bilinear;
    logic perspective_correct_enable;
  } tmc_mode_type;

  typedef struct packed {
    logic signed [15:0] s;
    logic signed [15:0] t;
    logic signed [15:0] w;
    logic [5:0] lod;
    logic [23:0] c_other;
    logic [7:0] a_other;
  } tmc_pixel_type;

  typedef struct packed {
    logic [7:0] s0;
    logic [7:0] s1;
    logic [7:0] t0;
    logic [7:0] t1;
    logic [3:0] frac_s;
    logic [3:0] frac_t;
    logic bilinear;
    logic trilinear;
    logic [3:0] format;
    logic ncc_select;
  } tmc_fetch_type;
endpackage

/* tmc_core.sv */
`timescale 1ns/1ps
// Overview of operation
// - Perspective bit: S/W, T/W else W=1.0
// - Filter bits pick point or bilinear
// - Point fetches one texel, bilinear four blended
// - LOD at or above minimum uses minification
// - Negative W with clamp forces S,T zero
// - LOD dither adds average of 3/8
// - Table select bit picks compression table
// - Clamp bits limit S, T to size
// - Without clamp, coordinates wrap by truncation
// - Format code taken from bits 11:8
// - Color unit zero-other and subtract-local bits
// - Color unit factor select, six codes
// - Color unit reverse, add, invert bits
// - Alpha unit zero, subtract, factor select
// - Alpha unit reverse, add, invert bits
// - Bit 30 selects trilinear mapping
// - Bit 31 picks 8-bit download addressing
// - Perspective costs no extra cycles
// - Format applies to reads and writes
// - Three identical color units, one alpha
module tmc_core #(
  parameter int unsigned DL_W = 20
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pix_valid,
  input wire tmc_pkg::tmc_pixel_type pix_in,
  output logic fetch_valid,
  output tmc_pkg::tmc_fetch_type fetch_out,
  input wire logic [3:0][31:0] texel_data,
  output logic out_valid,
  output logic [31:0] out_argb,
  input wire logic dl_valid,
  input wire logic [DL_W-1:0] dl_index,
  output logic dl_out_valid,
  output logic [DL_W:0] dl_mem_addr,
  output logic [3:0] dl_format
);
  import tmc_pkg::*;

  // Blend of a and b weighted by a four-bit fraction.
  function automatic logic [7:0] lerp8(input logic [7:0] a, input logic [7:0] b,
                                       input logic [3:0] f);
    logic [12:0] acc;
    acc = 13'(a * (5'h10 - {1'b0, f})) + 13'(b * f);
    return acc[11:4];
  endfunction

  // Clamp or wrap one integer coordinate against a power-of-two size.
  // Sizes above eight bits are not supported, since the address is only a byte wide.
  function automatic logic [7:0] fix_coord(input logic signed [12:0] i, input logic [3:0] lg,
                                           input logic clamp);
    logic [12:0] mask;
    mask = 13'((13'h1 << lg) - 13'h1);
    if (!clamp)
      return 8'(i & $signed(mask));
    else if (i < 0)
      return 8'h00;
    else if (i > $signed(mask))
      return mask[7:0];
    else
      return i[7:0];
  endfunction

  // One combine unit; every unit of the pixel is this same function.
  function automatic logic [7:0] combine(input tmc_comb_type c, input logic [7:0] other,
                                         input logic [7:0] loc, input logic [7:0] loc_a,
                                         input logic [7:0] oth_a, input logic [5:0] lod);
    logic signed [9:0] diff;
    logic [7:0] f;
    logic signed [19:0] prod;
    logic signed [11:0] sum;
    diff = $signed({2'b00, c.zero_other ? 8'h00 : other})
         - $signed({2'b00, c.sub_local ? loc : 8'h00});
    case (c.factor_select)
      TMC_F_ZERO: f = 8'h00;
      TMC_F_LOCAL: f = loc;
      TMC_F_OTHER_A: f = oth_a;
      TMC_F_LOCAL_A: f = loc_a;
      TMC_F_LOD: f = {lod, 2'b00};
      TMC_F_LOD_FRAC: f = {lod[1:0], 6'h00};
      default: f = 8'h00;
    endcase
    if (!c.reverse_blend)
      f = ~f;
    // Adding one to the factor lets a full factor pass the input unchanged after the shift.
    prod = diff * $signed({11'h000, f} + 19'sh1);
    sum = 12'(prod >>> 8);
    sum = sum + $signed({4'h0, c.add_local_color ? loc : 8'h00});
    sum = sum + $signed({4'h0, c.add_local_alpha ? loc_a : 8'h00});
    if (sum < 0)
      sum = 12'sh000;
    else if (sum > 12'sh0FF)
      sum = 12'sh0FF;
    return c.invert_result ? ~sum[7:0] : sum[7:0];
  endfunction

  tmc_mode_type mode_reg, mode1_reg;
  logic [5:0] lodmin_reg;
  logic [7:0] size_reg;
  logic [31:0] count_reg, prdata_next;
  logic [1:0] dither_reg;
  tmc_fetch_type fetch_reg, fetch_next;
  logic fetch_valid_reg, out_valid_reg, dl_out_valid_reg;
  logic [5:0] lod1_reg;
  logic [23:0] c_other1_reg;
  logic [7:0] a_other1_reg;
  logic [31:0] out_argb_reg;
  logic [DL_W:0] dl_mem_addr_reg;
  logic [3:0] dl_format_reg;

  // APB decode; the slave answers in the access phase with no wait state.
  // Read data is loaded in the setup phase so that it already stands at the access edge.
  wire apb_acc = psel && penable;
  wire apb_setup = psel && !penable;
  wire hit_mode = paddr == TMC_MODE_OFS;
  wire hit_lodmin = paddr == TMC_LODMIN_OFS;
  wire hit_size = paddr == TMC_SIZE_OFS;
  wire hit_count = paddr == TMC_COUNT_OFS;
  wire mapped = hit_mode || hit_lodmin || hit_size || hit_count;
  wire wr_mode = apb_acc && pwrite && hit_mode;
  assign pready = 1'b1;
  assign pslverr = apb_acc && (!mapped || (pwrite && hit_count));

  always_comb
  begin
    prdata_next = 32'h0000_0000;
    if (hit_mode)
      prdata_next = mode_reg;
    else if (hit_lodmin)
      prdata_next = {26'h0000000, lodmin_reg};
    else if (hit_size)
      prdata_next = {24'h000000, size_reg};
    else if (hit_count)
      prdata_next = count_reg;
  end

  // Register writes; the pixel counter shows that the pipe is moving.
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      mode_reg <= TMC_MODE_RESET;
      lodmin_reg <= TMC_LODMIN_RESET;
      size_reg <= TMC_SIZE_RESET;
      count_reg <= 32'h0000_0000;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr_mode)
        mode_reg <= pwdata;
      if (apb_acc && pwrite && hit_lodmin)
        lodmin_reg <= pwdata[5:0];
      if (apb_acc && pwrite && hit_size)
        size_reg <= pwdata[7:0];
      if (out_valid_reg)
        count_reg <= count_reg + 32'h0000_0001;
      if (apb_setup && !pwrite)
        prdata <= prdata_next;
    end
  end

  // Coordinate path: divide, negative W clamp, then clamp or wrap.
  // The divide is purely combinational so perspective costs no extra cycle.
  wire signed [15:0] w_eff = pix_in.w == 16'sh0000 ? TMC_W_ONE : pix_in.w;
  wire signed [27:0] s_num = 28'(pix_in.s) <<< TMC_W_FRAC;
  wire signed [27:0] t_num = 28'(pix_in.t) <<< TMC_W_FRAC;
  wire signed [27:0] s_div = s_num / 28'(w_eff);
  wire signed [27:0] t_div = t_num / 28'(w_eff);
  wire persp = mode_reg.perspective_correct_enable;
  wire signed [15:0] s_pc = persp ? s_div[15:0] : pix_in.s;
  wire signed [15:0] t_pc = persp ? t_div[15:0] : pix_in.t;
  wire neg_w_zero = mode_reg.clamp_neg_w && pix_in.w < 0;
  wire signed [15:0] s_fx = neg_w_zero ? 16'sh0000 : s_pc;
  wire signed [15:0] t_fx = neg_w_zero ? 16'sh0000 : t_pc;
  wire signed [12:0] s_int = 13'(s_fx >>> TMC_ST_FRAC);
  wire signed [12:0] t_int = 13'(t_fx >>> TMC_ST_FRAC);
  // Dither cycles 0..3 quarter steps, an average of 3/8 of a level.
  wire [6:0] lod_sum = {1'b0, pix_in.lod} + {5'h00, mode_reg.lod_dither ? dither_reg : 2'b00};
  wire [5:0] lod_d = lod_sum[6] ? 6'h3F : lod_sum[5:0];
  wire minify = lod_d >= lodmin_reg;
  wire bil = mode_reg.trilinear
          || (minify ? mode_reg.min_bilinear : mode_reg.mag_bilinear);

  always_comb
  begin
    fetch_next.s0 = fix_coord(s_int, size_reg[3:0], mode_reg.clamp_s);
    fetch_next.t0 = fix_coord(t_int, size_reg[7:4], mode_reg.clamp_t);
    fetch_next.s1 = fetch_next.s0;
    fetch_next.t1 = fetch_next.t0;
    if (bil)
    begin
      fetch_next.s1 = fix_coord(s_int + 13'sh1, size_reg[3:0], mode_reg.clamp_s);
      fetch_next.t1 = fix_coord(t_int + 13'sh1, size_reg[7:4], mode_reg.clamp_t);
    end
    fetch_next.frac_s = bil ? s_fx[3:0] : 4'h0;
    fetch_next.frac_t = bil ? t_fx[3:0] : 4'h0;
    fetch_next.bilinear = bil;
    fetch_next.trilinear = mode_reg.trilinear;
    fetch_next.format = mode_reg.format;
    fetch_next.ncc_select = mode_reg.ncc_select;
  end

  // Stage one: the mode is captured with each pixel so a later write
  // cannot reach a pixel that is already in the pipe.
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      fetch_valid_reg <= 1'b0;
      fetch_reg <= '0;
      mode1_reg <= TMC_MODE_RESET;
      lod1_reg <= 6'h00;
      c_other1_reg <= 24'h000000;
      a_other1_reg <= 8'h00;
      dither_reg <= 2'b00;
    end
    else
    begin
      fetch_valid_reg <= pix_valid;
      if (pix_valid)
      begin
        fetch_reg <= fetch_next;
        mode1_reg <= mode_reg;
        lod1_reg <= lod_d;
        c_other1_reg <= pix_in.c_other;
        a_other1_reg <= pix_in.a_other;
        dither_reg <= dither_reg + 2'b01;
      end
    end
  end

  // Stage two: texels come back in the same cycle as the fetch; blend, then combine.
  logic [31:0] texel;
  logic [31:0] comb_next;
  always_comb
  begin
    texel = texel_data[0];
    if (fetch_reg.bilinear)
      for (int k = 0; k < 4; k++)
        texel[8*k +: 8] = lerp8(lerp8(texel_data[0][8*k +: 8], texel_data[1][8*k +: 8],
                                      fetch_reg.frac_s),
                                lerp8(texel_data[2][8*k +: 8], texel_data[3][8*k +: 8],
                                      fetch_reg.frac_s),
                                fetch_reg.frac_t);
    for (int k = 0; k < 3; k++)
      comb_next[8*k +: 8] = combine(mode1_reg.color_unit, c_other1_reg[8*k +: 8],
                                    texel[8*k +: 8], texel[31:24], a_other1_reg,
                                    lod1_reg);
    comb_next[31:24] = combine(mode1_reg.alpha_unit, a_other1_reg, texel[31:24],
                               texel[31:24], a_other1_reg, lod1_reg);
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      out_valid_reg <= 1'b0;
      out_argb_reg <= 32'h0000_0000;
    end
    else
    begin
      out_valid_reg <= fetch_valid_reg;
      if (fetch_valid_reg)
        out_argb_reg <= comb_next;
    end
  end

  // Download addressing: 8-bit texels land on even words unless sequential.
  // Wide formats already fill half a word, so they always count sequentially.
  wire narrow = mode_reg.format < TMC_FMT_WIDE;
  wire [DL_W:0] dl_addr_next = (narrow && !mode_reg.seq_download)
                             ? {dl_index, 1'b0} : {1'b0, dl_index};
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      dl_out_valid_reg <= 1'b0;
      dl_mem_addr_reg <= '0;
      dl_format_reg <= 4'h0;
    end
    else
    begin
      dl_out_valid_reg <= dl_valid;
      if (dl_valid)
      begin
        dl_mem_addr_reg <= dl_addr_next;
        dl_format_reg <= mode_reg.format;
      end
    end
  end

  assign fetch_valid = fetch_valid_reg;
  assign fetch_out = fetch_reg;
  assign out_valid = out_valid_reg;
  assign out_argb = out_argb_reg;
  assign dl_out_valid = dl_out_valid_reg;
  assign dl_mem_addr = dl_mem_addr_reg;
  assign dl_format = dl_format_reg;

  // Checks kept beside the logic they guard.
  wire [7:0] s_mask = 8'((9'h1 << size_reg[3:0]) - 9'h1);
  wire [7:0] t_mask = 8'((9'h1 << size_reg[7:4]) - 9'h1);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_neg_w_zero: assert property (pix_valid && neg_w_zero |=>
    fetch_reg.s0 == 8'h00 && fetch_reg.t0 == 8'h00) else $error("negative W not zeroed");
  a_point_single: assert property (fetch_valid_reg && !fetch_reg.bilinear |->
    fetch_reg.s1 == fetch_reg.s0 && fetch_reg.t1 == fetch_reg.t0) else $error("point fetch");
  a_filter_pick: assert property (pix_valid && !mode_reg.trilinear |=>
    fetch_reg.bilinear == ($past(minify) ? $past(mode_reg.min_bilinear)
                                         : $past(mode_reg.mag_bilinear)))
    else $error("wrong filter picked");
  a_trilin_bil: assert property (pix_valid && mode_reg.trilinear |=>
    fetch_reg.bilinear && fetch_reg.trilinear) else $error("trilinear not set");
  a_clamp_s: assert property (fetch_valid_reg && mode1_reg.clamp_s
    && $stable(size_reg) |-> fetch_reg.s0 <= s_mask) else $error("S outside width");
  a_wrap_t: assert property (fetch_valid_reg && !mode1_reg.clamp_t
    && $stable(size_reg) |-> (fetch_reg.t0 & ~t_mask) == 8'h00) else $error("T not wrapped");

  // Clamp keeps T inside the height; wrap keeps S inside the width.
  a_clamp_t: assert property (fetch_valid_reg && mode1_reg.clamp_t
    && $stable(size_reg) |-> fetch_reg.t0 <= t_mask) else $error("T outside height");
  a_wrap_s: assert property (fetch_valid_reg && !mode1_reg.clamp_s
    && $stable(size_reg) |-> (fetch_reg.s0 & ~s_mask) == 8'h00) else $error("S not wrapped");
  a_pipe_rate: assert property (pix_valid |=> fetch_valid ##1 out_valid)
    else $error("pixel stalled");
  a_mode_inflight: assert property (pix_valid && wr_mode |=>
    fetch_reg.format == $past(mode_reg.format) && mode1_reg == $past(mode_reg))
    else $error("in-flight pixel took new mode");
  a_ncc_follow: assert property (pix_valid |=>
    fetch_reg.ncc_select == $past(mode_reg.ncc_select)) else $error("table select lost");
  a_dl_addr: assert property (dl_valid && narrow && mode_reg.seq_download |=>
    dl_mem_addr == {1'b0, $past(dl_index)}) else $error("sequential address wrong");

  // Narrow texels in word mode land on even addresses; the format travels with the write.
  a_dl_even: assert property (dl_valid && narrow && !mode_reg.seq_download |=>
    dl_mem_addr == {$past(dl_index), 1'b0}) else $error("even word address wrong");
  a_dl_format: assert property (dl_valid |=> dl_format == $past(mode_reg.format))
    else $error("download format wrong");

  // Linear and unit-W pixels land on the integer part of S when nothing clamps.
  a_linear_s: assert property (pix_valid && !persp && !neg_w_zero
    && !mode_reg.clamp_s && size_reg == TMC_SIZE_RESET
    |=> fetch_reg.s0 == $past(8'(pix_in.s >>> TMC_ST_FRAC))) else $error("linear S wrong");
  a_persp_unit: assert property (pix_valid && persp && pix_in.w == TMC_W_ONE
    && !mode_reg.clamp_s && size_reg == TMC_SIZE_RESET
    |=> fetch_reg.s0 == $past(8'(pix_in.s >>> TMC_ST_FRAC)))
    else $error("divide by one changed S");

  // Level of detail passes untouched unless dither is on, then rises by three quarters at most.
  a_lod_plain: assert property (pix_valid && !mode_reg.lod_dither |=>
    lod1_reg == $past(pix_in.lod)) else $error("undithered LOD changed");
  a_lod_dither: assert property (pix_valid && mode_reg.lod_dither && pix_in.lod < 6'h3C
    |=> lod1_reg >= $past(pix_in.lod) && lod1_reg - $past(pix_in.lod) <= 6'h03)
    else $error("dithered LOD out of range");

  // Covers mark the main scenarios, so a run shows that each of them was reached.

  c_persp_pixel: cover property (pix_valid && persp ##2 out_valid);
  c_bilinear: cover property (fetch_valid_reg && fetch_reg.bilinear);
  c_mode_write: cover property (pix_valid && wr_mode ##1 fetch_valid);
  c_download: cover property (dl_valid && narrow && !mode_reg.seq_download);
  c_lod_dither: cover property (pix_valid && mode_reg.lod_dither ##1 fetch_valid);
endmodule

/* tmc_texmem.sv */
`timescale 1ns/1ps
module tmc_texmem
(
  input wire logic clock,
  input wire logic fetch_valid,
  input wire tmc_pkg::tmc_fetch_type fetch_out,
  output logic [3:0][31:0] texel_data
);
  import tmc_pkg::*;
  logic [31:0] noise_reg = 32'h0F0F_1234;
  logic [3:0][31:0] texel_next;

  // Each texel carries its own coordinates, so a wrong fetch address shows up in the colour.
  assign texel_next[0] = {8'hC3, fetch_out.s0, fetch_out.t0, 8'h5A};
  assign texel_next[1] = {8'hC3, fetch_out.s1, fetch_out.t0, 8'h5B};
  assign texel_next[2] = {8'hC3, fetch_out.s0, fetch_out.t1, 8'h5C};
  assign texel_next[3] = {8'hC3, fetch_out.s1, fetch_out.t1, 8'h5D};
  // Outside a fetch the bus shows a walking pattern, so a late sample never looks right.
  assign texel_data = fetch_valid ? texel_next : {4{noise_reg}};

  // The pattern changes every cycle.
  always_ff @(posedge clock)
  begin
    noise_reg <= {noise_reg[30:0], ~noise_reg[31]};
  end
endmodule

/* tmc_core_tb.sv */
`timescale 1ns/1ps
module tmc_core_tb;
  import tmc_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pix_valid = 1'b0;
  tmc_pixel_type pix_in = '0;
  logic fetch_valid;
  tmc_fetch_type fetch_out;
  logic [3:0][31:0] texel_data;
  logic out_valid;
  logic [31:0] out_argb;
  logic dl_valid = 1'b0;
  logic [19:0] dl_index = 20'h0;
  logic dl_out_valid;
  logic [20:0] dl_mem_addr;
  logic [3:0] dl_format;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  tmc_fetch_type fo;
  logic [31:0] res;

  tmc_core i_tmc_core (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pix_valid, .pix_in, .fetch_valid, .fetch_out, .texel_data, .out_valid, .out_argb,
    .dl_valid, .dl_index, .dl_out_valid, .dl_mem_addr, .dl_format
  );
  tmc_texmem i_tmc_texmem (.clock, .fetch_valid, .fetch_out, .texel_data);

  // A 40 ns period.
  always #20 clock = ~clock;

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hang is cut short well beyond the fewer than two hundred cycles the run needs.
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clock);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do
      @(posedge clock);
    while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One pixel; the fetch and the result are taken in the cycles they stand.
  task automatic pix(input logic [15:0] sv, input logic [15:0] tv, input logic [15:0] wv);
    @(posedge clock);
    pix_valid <= 1'b1;
    pix_in <= '{s: sv, t: tv, w: wv, lod: 6'h00, c_other: 24'h123456, a_other: 8'h9A};
    @(posedge clock);
    pix_valid <= 1'b0;
    #1;
    check(fetch_valid, 32'h1);
    fo = fetch_out;
    @(posedge clock);
    #1;
    check(out_valid, 32'h1);
    res = out_argb;
  endtask

  task automatic t_regs();
    apb(1'b0, TMC_MODE_OFS, 32'h0);
    check(rd, TMC_MODE_RESET);
    apb(1'b0, TMC_SIZE_OFS, 32'h0);
    check(rd, 32'h88);
    apb(1'b0, TMC_COUNT_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, TMC_COUNT_OFS, 32'h5);
    check(err, 32'h1);
    apb(1'b1, TMC_MODE_OFS, 32'hA5A5_5A5A);
    apb(1'b0, TMC_MODE_OFS, 32'h0);
    check(err, 32'h0);
    check(rd, 32'hA5A5_5A5A);
  endtask

  // With dither on and a minimum of one quarter level, only the pixel that draws the
  // zero step stays below the minimum, so one pixel in four is magnified.
  task automatic t_dither();
    int n_bil;
    n_bil = 0;
    apb(1'b1, TMC_MODE_OFS, 32'h0000_0014);
    apb(1'b1, TMC_LODMIN_OFS, 32'h1);
    repeat (4)
    begin
      pix(16'd168, 16'd32, TMC_W_ONE);
      n_bil = n_bil + fo.bilinear;
    end
    check(n_bil, 32'h1);
    apb(1'b1, TMC_LODMIN_OFS, 32'h0);
  endtask

  // A mode write that lands on the same edge as a pixel must leave that pixel alone.
  task automatic t_inflight();
    apb(1'b1, TMC_MODE_OFS, 32'h0000_0501);
    fork
      apb(1'b1, TMC_MODE_OFS, 32'h0000_0A01);
      begin
        @(posedge clock);
        pix(16'd48, 16'd64, TMC_W_ONE);
      end
    join
    check(fo.format, 32'h5);
    pix(16'd48, 16'd64, TMC_W_ONE);
    check(fo.format, 32'hA);
  endtask

  // Twenty-two pixels have left the pipe by now, each counted once.
  task automatic t_count();
    apb(1'b0, TMC_COUNT_OFS, 32'h0);
    check(rd, 32'h16);
  endtask

  // Filter choice turns on the minimum level of detail; trilinear forces a four-texel fetch.
  task automatic t_filter();
    apb(1'b1, TMC_MODE_OFS, 32'h0000_0004);
    pix(16'd168, 16'd32, TMC_W_ONE);
    check({fo.bilinear, fo.s0, fo.s1, fo.frac_s}, {1'b0, 8'h0A, 8'h0A, 4'h0});
    apb(1'b1, TMC_LODMIN_OFS, 32'h1);
    pix(16'd168, 16'd32, TMC_W_ONE);
    check({fo.bilinear, fo.s0, fo.s1, fo.frac_s}, {1'b1, 8'h0A, 8'h0B, 4'h8});
    check({fo.t0, fo.t1}, 16'h0203);
    apb(1'b1, TMC_MODE_OFS, 32'h4000_0D20);
    pix(16'd168, 16'd32, TMC_W_ONE);
    check({fo.bilinear, fo.trilinear}, 32'h3);
    check({fo.ncc_select, fo.format}, 32'h1D);
    apb(1'b1, TMC_LODMIN_OFS, 32'h0);
  endtask

  task automatic t_coord();
    apb(1'b1, TMC_MODE_OFS, 32'h40);
    pix(16'd4800, 16'hFFE0, TMC_W_ONE);
    check({fo.s0, fo.t0}, 16'hFFFE);
    apb(1'b1, TMC_MODE_OFS, 32'h80);
    pix(16'hFFE0, 16'd4800, TMC_W_ONE);
    check({fo.s0, fo.t0}, 16'hFEFF);
    apb(1'b1, TMC_SIZE_OFS, 32'h43);
    apb(1'b1, TMC_MODE_OFS, 32'h0);
    pix(16'd4800, 16'd4800, TMC_W_ONE);
    check({fo.s0, fo.t0}, 16'h040C);
    apb(1'b1, TMC_SIZE_OFS, 32'h88);
    pix(16'd1600, 16'd160, 16'h2000);
    check({fo.s0, fo.t0}, 16'h640A);
    apb(1'b1, TMC_MODE_OFS, 32'h1);
    pix(16'd1600, 16'd160, 16'h2000);
    check({fo.s0, fo.t0}, 16'h3205);
    pix(16'd80, 16'd80, 16'hF000);
    check({fo.s0, fo.t0}, 16'hFBFB);
    apb(1'b1, TMC_MODE_OFS, 32'h9);
    pix(16'd80, 16'd80, 16'hF000);
    check({fo.s0, fo.t0}, 16'h0000);
  endtask

  // Texel at (3,4) gives local colour 03045A and local alpha C3.
  task automatic t_comb(input logic [31:0] mode, input logic [31:0] exp);
    apb(1'b1, TMC_MODE_OFS, mode);
    pix(16'd48, 16'd64, TMC_W_ONE);
    check(res, exp);
  endtask

  task automatic t_dl(input logic [31:0] mode, input logic [20:0] addr, input logic [3:0] fmt);
    apb(1'b1, TMC_MODE_OFS, mode);
    @(posedge clock);
    dl_valid <= 1'b1;
    dl_index <= 20'h00123;
    @(posedge clock);
    dl_valid <= 1'b0;
    #1;
    check({dl_out_valid, dl_mem_addr}, {1'b1, addr});
    check(dl_format, fmt);
  endtask

  // Reset for two cycles, then every scenario in turn.
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_filter();
    t_coord();
    t_comb(32'h0000_0000, 32'h9A12_3456);
    t_comb(32'h0030_1000, 32'h00FF_FFFF);
    t_comb(32'h2024_1000, 32'hFF03_045A);
    t_comb(32'h0002_0000, 32'h9A00_0000);
    t_comb(32'h0828_1000, 32'hC3C3_C3C3);
    t_comb(32'h0180_8000, 32'h2407_1422);
    t_dither();
    t_inflight();
    t_count();
    t_dl(32'h0000_0300, 21'h000246, 4'h3);
    t_dl(32'h8000_0300, 21'h000123, 4'h3);
    t_dl(32'h0000_0800, 21'h000123, 4'h8);
    tally_and_finish();
  end
endmodule
